// ==== bench/iva_pmem_model.sv ====
// program memory model answering vector reads
`timescale 1ns/10ps
module iva_pmem_model (
   // read port
   input  wire logic        mclk,
   input  wire logic        pmem_rd,
   input  wire logic [14:0] pmem_addr,
   output logic      [7:0]  pmem_data
);
   // read is combinational: the arbiter takes the byte in the read cycle;
   // outside reads the bus shows the inverse so a stale byte cannot pass
   logic [7:0] byte_val;
   assign byte_val  = pmem_addr[7:0] ^ {1'b0, pmem_addr[14:8]};
   assign pmem_data = pmem_rd ? byte_val : ~byte_val;
endmodule : iva_pmem_model

// ==== bench/test_interrupt_vector_arbiter.sv ====
// self-checking bench of the interrupt vector arbiter
`timescale 1ns/10ps
module test_interrupt_vector_arbiter;
   logic        mclk, rst_n, disp, clr, trap, rd, load, busy, flag;
   logic [14:0] pc_in, addr, pc_out;
   logic [13:0] irq;
   logic [7:0]  data;
   int          errors, check_count;
   iva_arbiter dut (.mclk(mclk), .rst_n(rst_n), .vector_dispatch_instr(disp),
      .clear_trap_pending_instr(clr), .trap_opcode(trap), .pc_in(pc_in),
      .irq_active(irq), .pmem_data(data), .pmem_addr(addr), .pmem_rd(rd),
      .pc_out(pc_out), .pc_load(load), .busy(busy), .trap_pending_flag(flag));
   iva_pmem_model mem (.mclk(mclk), .pmem_rd(rd), .pmem_addr(addr),
      .pmem_data(data));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(string n, logic [14:0] e, logic [14:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic step;
      @(posedge mclk);
      #1;
   endtask : step
   // again raises a second dispatch while busy, which must be ignored
   task automatic dispatch(logic [14:0] pc, logic [13:0] v, logic [7:0] off,
                           bit again);
      logic [14:0] a;
      a = {pc[14:8] + 7'(pc[7:0] == 8'hFF), off};
      step;
      disp = 1'b1;
      pc_in = pc;
      irq = v;
      step;
      disp = again;
      pc_in = ~pc;
      irq = ~v;
      chk("address", a, addr);
      chk("strobe", 15'h1, rd);
      step;
      disp = 1'b0;
      chk("address+1", a + 15'h1, addr);
      step;
      chk("load", 15'h1, load);
      chk("vector", {a[6:0] ^ a[14:8], a[7:0] ^ {1'b0, a[14:8]} ^ 8'h01},
          pc_out);
      step;
      chk("load end", 15'h0, load);
      chk("busy end", 15'h0, busy);
   endtask : dispatch
   task automatic t_trap;
      chk("flag", 15'h0, flag);
      trap = 1'b1;
      step;
      trap = 1'b0;
      chk("flag", 15'h1, flag);
      dispatch(15'h0123, 14'h3FFF, 8'hFE, 1'b0);
      clr = 1'b1;
      step;
      trap = 1'b1;
      chk("flag", 15'h0, flag);
      step;
      clr = 1'b0;
      trap = 1'b0;
      chk("flag", 15'h1, flag);
      clr = 1'b1;
      step;
      clr = 1'b0;
      chk("flag", 15'h0, flag);
      $display("trap test done");
   endtask : t_trap
   task automatic t_rank;
      for (int i = 0; i < 14; i++) begin
         dispatch(15'h0123, 14'((2 << i) - 1), 8'(8'hE2 + 2 * i), i[0]);
      end
      dispatch(15'h0123, 14'h0000, 8'hE0, 1'b0);
      dispatch(15'h02FF, 14'h1000, 8'hFA, 1'b0);
      dispatch(15'h7AFE, 14'h1FFF, 8'hFA, 1'b1);
      $display("rank test done");
   endtask : t_rank
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   initial begin
      {rst_n, disp, clr, trap, pc_in, irq} = '0;
      errors = 0;
      check_count = 0;
      step;
      step;
      rst_n = 1'b1;
      t_trap;
      t_rank;
      finish_test;
   end
   initial begin
      #20000;
      errors++;
      finish_test;
   end
endmodule : test_interrupt_vector_arbiter

// ==== hw/iva_arbiter.sv ====
// interrupt vector arbiter with software trap pending flag
`timescale 1ns/10ps
`include "iva_defs.svh"

// How it works
// - a dispatch instruction starts arbitration giving an even E0..FE offset.
// - active sources are sampled only in the first dispatch cycle.
// - an active software trap always yields FE.
// - external pin without trap or reserved bit 13 yields FA, lower ranks lower even values.
// - only the low byte of the program counter is replaced, except at a block's last byte, where the next block's upper bits are used.
// - the vector at that address is fetched and loaded into the counter.
// - the trap pending flag is internal and not software reachable.
// - reset clears the trap pending flag.
// - a software trap sets the trap pending flag.
// - the clear-trap-pending instruction clears the flag unless a software trap comes in the same cycle.
// - rank runs trap, reserved, external, timers, serial, reserved, port.
// - a vector is two bytes, high byte at the lower address.
// - with nothing active the E0 default slot is used.
// - a dispatch at a block's last byte uses the next block's table.
module iva_arbiter
   import iva_pkg::*;
#(
   parameter int PC_W  = `IVA_PC_W,
   parameter int SRC_N = `IVA_SRC_N
) (
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst_n,
   // sequencer
   input  wire logic            vector_dispatch_instr,
   input  wire logic            clear_trap_pending_instr,
   input  wire logic            trap_opcode,
   input  wire logic [PC_W-1:0] pc_in,
   // sources, bit 13 highest maskable (reserved), bit 0 port edge
   input  wire logic [SRC_N-2:0] irq_active,
   // program memory
   input  wire logic [7:0]      pmem_data,
   output logic      [PC_W-1:0] pmem_addr,
   output logic                 pmem_rd,
   // program counter load
   output logic      [PC_W-1:0] pc_out,
   output logic                 pc_load,
   output logic                 busy,
   output logic                 trap_pending_flag
);
   // ****************************************************************
   // parameter check
   // ****************************************************************
   // the vector table layout only fits a 15-bit counter and 15 ranks
   if (PC_W != `IVA_PC_W || SRC_N != `IVA_SRC_N) begin : g_bad_param
      $error("iva_arbiter: unsupported parameters");
   end

   // ****************************************************************
   // state
   // ****************************************************************

   typedef struct packed {
      iva_state_t      st;
      logic            stp;
      logic [PC_W-1:0] addr;
      logic [7:0]      hi;
      logic [PC_W-1:0] pc;
      logic            ld;
      logic            rd;
      // busy kept in its own flop so the pin carries no decode glitch
      logic            bsy;
   } iva_st_t;

   iva_st_t s_r, s_nxt;

   // ****************************************************************
   // arbitration
   // ****************************************************************
   // sources are scanned from the lowest up so the highest active one
   // writes last; the trap overrides everything
   function automatic logic [7:0] rank(input logic trap,
                                       input logic [SRC_N-2:0] act);
      logic [7:0] v;
      v = `IVA_VEC_BASE;
      for (int i = 0; i < SRC_N - 1; i++) begin
         if (act[i]) begin
            v = `IVA_VEC_BASE + 8'((i + 1) * `IVA_VEC_STEP);
         end
      end
      if (trap) begin
         v = `IVA_VEC_TRAP;
      end
      return v;
   endfunction : rank

   // ****************************************************************
   // next state
   // ****************************************************************
   logic [PC_W-1:0] blk_pc;
   always_comb begin
      s_nxt    = s_r;
      s_nxt.ld = 1'b0;
      s_nxt.rd = 1'b0;
      // set wins over clear
      if (clear_trap_pending_instr) s_nxt.stp = 1'b0;
      if (trap_opcode)              s_nxt.stp = 1'b1;
      // next block when dispatch sits on the block's last byte
      blk_pc = (pc_in[7:0] == `IVA_LAST_IN_BLK) ?
               PC_W'(pc_in + PC_W'(1)) : pc_in;
      unique case (s_r.st)
         IVA_IDLE: begin
            // sources are looked at only here, later cycles ignore them
            if (vector_dispatch_instr) begin
               s_nxt.addr = {blk_pc[PC_W-1:8],
                  rank(s_r.stp, irq_active)};
               s_nxt.rd   = 1'b1;
               s_nxt.bsy  = 1'b1;
               s_nxt.st   = IVA_HI;
            end
         end
         IVA_HI: begin
            // memory answers within the read cycle
            s_nxt.hi   = pmem_data;
            s_nxt.addr = PC_W'(s_r.addr + PC_W'(1));
            s_nxt.rd   = 1'b1;
            s_nxt.st   = IVA_LO;
         end
         IVA_LO: begin
            // top bit of the high byte is dropped, vectors are 15 bits
            s_nxt.pc = {s_r.hi[PC_W-9:0], pmem_data};
            s_nxt.ld = 1'b1;
            s_nxt.st = IVA_LOAD;
         end
         IVA_LOAD: begin
            s_nxt.bsy = 1'b0;
            s_nxt.st  = IVA_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: IVA_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // flag leaves only as a status pin, no software path to it
   assign trap_pending_flag = s_r.stp;
   assign pmem_addr = s_r.addr;
   assign pmem_rd   = s_r.rd;
   assign pc_out    = s_r.pc;
   assign pc_load   = s_r.ld;
   assign busy      = s_r.bsy;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   trap_set_a: assert property (trap_opcode |=> trap_pending_flag)
      else $error("trap did not set pending flag");
   trap_clr_a: assert property (clear_trap_pending_instr && !trap_opcode
      |=> !trap_pending_flag)
      else $error("clear did not drop pending flag");
   trap_vec_a: assert property (!busy && vector_dispatch_instr
      && trap_pending_flag |=> pmem_addr[7:0] == 8'hFE)
      else $error("trap did not select FE");
   even_off_a: assert property (pmem_rd && $past(!busy)
      |-> pmem_addr[0] == 1'b0 && pmem_addr[7:5] == 3'h7)
      else $error("offset not even in E0..FE");
   upper_keep_a: assert property (!busy && vector_dispatch_instr
      && pc_in[7:0] != 8'hFF |=> pmem_addr[14:8] == $past(pc_in[14:8]))
      else $error("upper byte changed");
   next_blk_a: assert property (!busy && vector_dispatch_instr
      && pc_in[7:0] == 8'hFF
      |=> pmem_addr[14:8] == $past(pc_in[14:8]) + 7'h01)
      else $error("block wrap wrong");
   load_time_a: assert property (!busy && vector_dispatch_instr
      |-> ##3 pc_load)
      else $error("vector not loaded in time");
   ext_vec_a: assert property (!busy && vector_dispatch_instr
      && !trap_pending_flag && !irq_active[13] && irq_active[12]
      |=> pmem_addr[7:0] == 8'hFA)
      else $error("external did not select FA");
   dflt_vec_a: assert property (!busy && vector_dispatch_instr
      && !trap_pending_flag && irq_active == '0
      |=> pmem_addr[7:0] == 8'hE0)
      else $error("default slot not E0");

   // pending flag
   set_wins_a: assert property (trap_opcode && clear_trap_pending_instr
      |=> trap_pending_flag)
      else $error("clear beat a simultaneous trap");
   flag_hold_a: assert property (!trap_opcode && !clear_trap_pending_instr
      |=> trap_pending_flag == $past(trap_pending_flag))
      else $error("pending flag moved without trap or clear");

   // fetch sequence
   second_rd_a: assert property (pmem_rd && $past(!busy)
      |=> pmem_rd && pmem_addr == $past(pmem_addr) + 15'h0001)
      else $error("low byte not read from next address");
   busy_span_a: assert property (!busy && vector_dispatch_instr
      |=> busy [*3] ##1 !busy)
      else $error("busy span wrong");
   load_pulse_a: assert property (pc_load |=> !pc_load && !busy)
      else $error("load pulse too long");
   rd_busy_a: assert property (pmem_rd |-> busy)
      else $error("read outside a dispatch");

   dispatch_c: cover property (!busy && vector_dispatch_instr);
   trap_disp_c: cover property (trap_pending_flag && vector_dispatch_instr);
   wrap_c: cover property (vector_dispatch_instr && pc_in[7:0] == 8'hFF);
   set_clr_c: cover property (trap_opcode && clear_trap_pending_instr);
   ext_c: cover property (!busy && vector_dispatch_instr && irq_active[12]);
endmodule : iva_arbiter

// ==== hw/iva_defs.svh ====
// constants of the interrupt vector arbiter
`ifndef IVA_DEFS_SVH
`define IVA_DEFS_SVH
`define IVA_VEC_BASE     8'hE0
`define IVA_VEC_TRAP     8'hFE
`define IVA_VEC_EXT      8'hFA
`define IVA_VEC_STEP     2
`define IVA_PC_W         15
`define IVA_SRC_N        15
`define IVA_SRC_TRAP     14
`define IVA_LAST_IN_BLK  8'hFF
`endif

// ==== hw/iva_pkg.sv ====
// types of the interrupt vector arbiter
package iva_pkg;
   typedef enum logic [3:0] {
      IVA_IDLE = 4'h1,
      IVA_HI   = 4'h2,
      IVA_LO   = 4'h4,
      IVA_LOAD = 4'h8
   } iva_state_t;
endpackage : iva_pkg
